// [include/tlb_pkg.sv]
/*
  Constants, types and helpers shared by the translation lookaside buffer.
  Assumes a 64-bit virtual address, 24-bit region identifiers, 50-bit
  physical addresses and page sizes given as log2 of the byte count.
*/
// Summary of operation
// - Separate instruction and data buffers; data serves spiller, walker
// - Pinned insert writes exactly the named slot
// - Pinned purge selects by address, size, region
// - Pinned translations never evicted for others
// - Only pinned purge, pinned insert to its slot, or error removes pinned
// - Error drops pinned entries and raises machine check
// - Eight instruction and eight data pinned slots
// - Any slot takes any mapping, no read path
// - Valid pinned slots never chosen as cache victims
// - Device alone picks cache replacement victims
// - Distinct instruction and data cache inserts
// - Local purge removes overlapping cache entries both streams
// - Global purge broadcasts; remote purges are honoured
// - Cache purges leave pinned entries intact
// - Entry purge empties local caches, never broadcast
// - At least one cache entry per stream
// - Device may drop or overpurge cache entries
// - Error may drop cache, raise corrected check
// - Last inserted cache entry held until safe
// - Instruction and data entries never cross streams
// - Top three address bits pick region register
// - Overlap means same region and intersecting ranges
`default_nettype none
package tlb_pkg;
  localparam int VA_W = 64; // Virtual address width
  localparam int RID_W = 24; // Region identifier width
  localparam int VPN_W = 61; // Address bits below the region select
  localparam int PS_W = 6; // Page size, log2 bytes
  localparam int PA_W = 50; // Physical address width
  localparam int PIN_N = 8; // Pinned slots per stream
  localparam int TC_N = 4; // Dynamic cache entries per stream
  localparam int ENT_N = PIN_N + TC_N; // Searchable entries per stream
  localparam int RR_N = 8; // Region registers
  localparam int STR_N = 2; // Instruction and data streams
  localparam int RSEL_HI = 63; // Region select, top bit
  localparam int RSEL_LO = 61; // Region select, low bit
  localparam logic STR_INSTR = 1'h0; // Instruction stream index
  localparam logic STR_DATA = 1'h1; // Data stream index
  localparam logic [PS_W-1:0] PS_LOOKUP = 6'h00; // Lookups carry no size

  // Maintenance commands
  typedef enum logic [2:0] {
    TLB_OP_INS_PIN = 3'h0, // Pinned slot insert
    TLB_OP_PRG_PIN = 3'h1, // Pinned slot purge
    TLB_OP_INS_TC = 3'h2, // Dynamic cache insert
    TLB_OP_PRG_LOC = 3'h3, // Local cache purge
    TLB_OP_PRG_GLB = 3'h4, // Global cache purge
    TLB_OP_PRG_ENT = 3'h5 // Purge all local cache entries
  } tlb_op_t;

  // Requester on the data stream
  typedef enum logic [1:0] {
    TLB_SRC_DATA = 2'h0, // Load or store
    TLB_SRC_SPILL = 2'h1, // Register stack spiller
    TLB_SRC_WALK = 2'h2 // Hashed page table walker
  } tlb_src_t;

  // Forward-progress hold of the last cache insert
  typedef enum logic [1:0] {
    TLB_FP_IDLE = 2'h0, // Nothing held
    TLB_FP_HOLD = 2'h1, // Held while collection is off
    TLB_FP_ARMED = 2'h2 // Return done, waiting for one clean instruction
  } tlb_fp_t;

  // One translation
  typedef struct packed {
    logic valid; // Entry in use
    logic [RID_W-1:0] region_identifier; // Region identifier
    logic [VPN_W-1:0] virtual_page_number; // Page-aligned address below region select
    logic [PS_W-1:0] ps; // Page size
    logic [PA_W-1:0] pa; // Page-aligned physical address
  } tlb_entry_t;

  // Ones below the page size
  function automatic logic [VPN_W-1:0] tlb_lo_mask(input logic [PS_W-1:0] ps);
    tlb_lo_mask = (61'h1 << ps) - 61'h1;
  endfunction : tlb_lo_mask
endpackage : tlb_pkg
`default_nettype wire

// [hdl/tlb_match.sv]
/*
  Compares one stored translation with a query address and page size.
  Assumes entries are stored page aligned; purely combinational.
*/
`timescale 1ns/10ps
`default_nettype none
module tlb_match (
  input wire tlb_pkg::tlb_entry_t ent_in, // Stored translation
  input wire logic [tlb_pkg::RID_W-1:0] rid_in, // Query region identifier
  input wire logic [tlb_pkg::VPN_W-1:0] va_in, // Query address
  input wire logic [tlb_pkg::PS_W-1:0] ps_in, // Query page size
  output logic hit_out // Valid and ranges intersect
);
  import tlb_pkg::*;
  logic [PS_W-1:0] ps_max; // Larger of the two sizes

  // Ranges intersect when bits above the larger page agree
  always_comb begin
    ps_max = (ent_in.ps > ps_in) ? ent_in.ps : ps_in;
    hit_out = ent_in.valid && (ent_in.region_identifier == rid_in) &&
              ~|((ent_in.virtual_page_number ^ va_in) & ~tlb_lo_mask(ps_max));
  end
endmodule : tlb_match
`default_nettype wire

// [hdl/tlb_buffer.sv]
/*
  Instruction and data translation buffers with pinned slots and a small
  dynamic cache per stream, plus maintenance commands and purges.
  Assumes one maintenance command per cycle, synchronous inputs, and that
  the core feeds collection state, return and completion events.
*/
`timescale 1ns/10ps
`default_nettype none
module tlb_buffer (
  input wire logic clock_in, // Core clock
  input wire logic reset_in, // Synchronous reset, high
  input wire logic rr_write_in, // Region register write strobe
  input wire logic [2:0] rr_index_in, // Region register number
  input wire logic [tlb_pkg::RID_W-1:0] rr_rid_in, // Region identifier value
  input wire logic op_valid_in, // Maintenance command strobe
  input wire tlb_pkg::tlb_op_t op_code_in, // Maintenance command
  input wire logic op_stream_in, // 0 instruction, 1 data
  input wire logic [2:0] op_slot_in, // Pinned slot number
  input wire logic [tlb_pkg::VA_W-1:0] op_va_in, // Command address
  input wire logic [tlb_pkg::PS_W-1:0] op_ps_in, // Command page size
  input wire logic [tlb_pkg::PA_W-1:0] op_pa_in, // Insert physical address
  input wire logic remote_purge_valid_in, // Incoming global purge
  input wire logic [tlb_pkg::VPN_W-1:0] remote_purge_va_in, // Its address
  input wire logic [tlb_pkg::PS_W-1:0] remote_purge_ps_in, // Its page size
  input wire logic [tlb_pkg::RID_W-1:0] remote_purge_rid_in, // Its region
  output logic remote_purge_ready_out, // Remote purge taken this cycle
  output logic global_purge_out, // Broadcast pulse
  output logic [tlb_pkg::VPN_W-1:0] global_purge_va_out, // Broadcast address
  output logic [tlb_pkg::PS_W-1:0] global_purge_ps_out, // Broadcast size
  output logic [tlb_pkg::RID_W-1:0] global_purge_rid_out, // Broadcast region
  input wire logic instr_req_valid_in, // Fetch lookup strobe
  input wire logic [tlb_pkg::VA_W-1:0] instr_va_in, // Fetch address
  output logic instr_resp_valid_out, // Fetch answer
  output logic instr_hit_out, // Fetch translated
  output logic instr_miss_out, // Fetch missed
  output logic [tlb_pkg::PA_W-1:0] instr_pa_out, // Fetch physical address
  input wire logic data_req_valid_in, // Data lookup strobe
  input wire logic [tlb_pkg::VA_W-1:0] data_va_in, // Data address
  input wire tlb_pkg::tlb_src_t data_src_in, // Data requester
  output logic data_resp_valid_out, // Data answer
  output logic data_hit_out, // Data translated
  output logic data_miss_out, // Data missed
  output logic [tlb_pkg::PA_W-1:0] data_pa_out, // Data physical address
  output var tlb_pkg::tlb_src_t data_resp_src_out, // Requester echoed
  input wire logic interruption_collection_in, // Collection state level
  input wire logic rfi_in, // Return that sets collection
  input wire logic insn_done_in, // Instruction completed cleanly
  input wire logic hw_error_in, // Hardware error pulse
  output logic machine_check_out, // Machine check abort pulse
  output logic corrected_check_out // Corrected check pulse
);
  import tlb_pkg::*;

  // Whole state of the block
  typedef struct packed {
    tlb_entry_t [STR_N-1:0][PIN_N-1:0] pin; // Pinned slots
    tlb_entry_t [STR_N-1:0][TC_N-1:0] tc; // Dynamic cache
    logic [RR_N-1:0][RID_W-1:0] rr; // Region registers
    logic [STR_N-1:0][1:0] ptr; // Round-robin victim pointers
    tlb_fp_t fp; // Forward-progress hold
    logic last_str; // Stream of last cache insert
    logic [1:0] last_idx; // Entry of last cache insert
    logic i_rv, i_hit, i_miss; // Fetch answer flags
    logic [PA_W-1:0] i_pa; // Fetch answer address
    logic d_rv, d_hit, d_miss; // Data answer flags
    logic [PA_W-1:0] d_pa; // Data answer address
    tlb_src_t d_src; // Data requester
    logic mc, cmc, gp; // Check and broadcast pulses
    logic [VPN_W-1:0] gp_va; // Broadcast address
    logic [PS_W-1:0] gp_ps; // Broadcast size
    logic [RID_W-1:0] gp_rid; // Broadcast region
  } tlb_state_t;

  tlb_state_t state_ff; // Registered state
  tlb_state_t nxt_state; // Next state
  tlb_entry_t [STR_N-1:0][ENT_N-1:0] ent; // Flat view, pinned first
  logic [STR_N-1:0][ENT_N-1:0] lk_m; // Lookup matches
  logic [STR_N-1:0][ENT_N-1:0] op_m; // Command overlap matches
  logic [STR_N-1:0][VA_W-1:0] lk_va; // Lookup address per stream
  logic [STR_N-1:0] lk_hit; // Lookup hit per stream
  logic [STR_N-1:0][PA_W-1:0] lk_pa; // Lookup address out per stream
  logic [VPN_W-1:0] q_va; // Command or remote address
  logic [PS_W-1:0] q_ps; // Command or remote size
  logic [RID_W-1:0] q_rid; // Command or remote region
  logic [1:0] victim; // Cache slot chosen for insert
  logic found; // Free cache slot seen
  tlb_entry_t new_ent; // Entry being inserted
  logic [VPN_W-1:0] m; // Low mask of lookup hit
  logic [VPN_W-1:0] ins_m; // Low mask of inserted page

  // Region select picks the identifier for commands
  assign lk_va[STR_INSTR] = instr_va_in;
  assign lk_va[STR_DATA] = data_va_in;
  assign q_va = op_valid_in ? op_va_in[VPN_W-1:0] : remote_purge_va_in;
  assign q_ps = op_valid_in ? op_ps_in : remote_purge_ps_in;
  assign q_rid = op_valid_in ? state_ff.rr[op_va_in[RSEL_HI:RSEL_LO]] : remote_purge_rid_in;
  assign remote_purge_ready_out = !op_valid_in && !hw_error_in;

  // One comparator pair per entry, per stream
  for (genvar s = 0; s < STR_N; s++) begin : g_str
    for (genvar k = 0; k < ENT_N; k++) begin : g_ent
      if (k < PIN_N) begin : g_pin
        assign ent[s][k] = state_ff.pin[s][k];
      end else begin : g_tc
        assign ent[s][k] = state_ff.tc[s][k-PIN_N];
      end
      tlb_match u_lk (
        .ent_in(ent[s][k]),
        .rid_in(state_ff.rr[lk_va[s][RSEL_HI:RSEL_LO]]),
        .va_in(lk_va[s][VPN_W-1:0]),
        .ps_in(PS_LOOKUP),
        .hit_out(lk_m[s][k])
      );
      tlb_match u_op (
        .ent_in(ent[s][k]),
        .rid_in(q_rid),
        .va_in(q_va),
        .ps_in(q_ps),
        .hit_out(op_m[s][k])
      );
    end
  end

  // Next-state logic: lookups, commands, purges, errors, hold
  always_comb begin
    nxt_state = state_ff;
    nxt_state.mc = 1'h0;
    nxt_state.cmc = 1'h0;
    nxt_state.gp = 1'h0;
    victim = state_ff.ptr[op_stream_in];
    found = 1'h0;
    m = '0;
    new_ent.valid = 1'h1;
    new_ent.region_identifier = q_rid;
    new_ent.ps = op_ps_in;
    ins_m = tlb_lo_mask(op_ps_in);
    new_ent.virtual_page_number = op_va_in[VPN_W-1:0] & ~ins_m;
    new_ent.pa = op_pa_in & ~ins_m[PA_W-1:0];
    // Lookups: each stream searches only its own arrays, pinned first
    for (int s = 0; s < STR_N; s++) begin
      lk_hit[s] = 1'h0;
      lk_pa[s] = '0;
      for (int k = ENT_N - 1; k >= 0; k--) begin
        if (lk_m[s][k]) begin
          lk_hit[s] = 1'h1;
          m = tlb_lo_mask(ent[s][k].ps);
          lk_pa[s] = (ent[s][k].pa & ~m[PA_W-1:0]) | (lk_va[s][PA_W-1:0] & m[PA_W-1:0]);
        end
      end
    end
    nxt_state.i_rv = instr_req_valid_in;
    nxt_state.i_hit = instr_req_valid_in && lk_hit[STR_INSTR];
    nxt_state.i_miss = instr_req_valid_in && !lk_hit[STR_INSTR];
    nxt_state.i_pa = lk_pa[STR_INSTR];
    nxt_state.d_rv = data_req_valid_in;
    nxt_state.d_hit = data_req_valid_in && lk_hit[STR_DATA];
    nxt_state.d_miss = data_req_valid_in && !lk_hit[STR_DATA];
    nxt_state.d_pa = lk_pa[STR_DATA];
    nxt_state.d_src = data_src_in;
    // Region register writes
    if (rr_write_in) begin
      nxt_state.rr[rr_index_in] = rr_rid_in;
    end
    // Forward-progress hold follows collection state
    unique case (state_ff.fp)
      TLB_FP_IDLE: begin
      end
      TLB_FP_HOLD: begin
        if (rfi_in) begin
          nxt_state.fp = TLB_FP_ARMED;
        end
      end
      TLB_FP_ARMED: begin
        if (insn_done_in && interruption_collection_in) begin
          nxt_state.fp = TLB_FP_IDLE;
        end else if (!interruption_collection_in) begin
          nxt_state.fp = TLB_FP_HOLD;
        end
      end
      default: nxt_state.fp = TLB_FP_IDLE;
    endcase
    if (hw_error_in) begin
      // Error drops everything and reports it
      for (int s = 0; s < STR_N; s++) begin
        for (int k = 0; k < PIN_N; k++) begin
          nxt_state.mc = nxt_state.mc | state_ff.pin[s][k].valid;
          nxt_state.pin[s][k].valid = 1'h0;
        end
        for (int k = 0; k < TC_N; k++) begin
          nxt_state.cmc = nxt_state.cmc | state_ff.tc[s][k].valid;
          nxt_state.tc[s][k].valid = 1'h0;
        end
      end
      nxt_state.fp = TLB_FP_IDLE;
    end else if (op_valid_in) begin
      case (op_code_in)
        TLB_OP_INS_PIN: begin
          // Overlap with any pinned slot of the same stream is a software fault: flag it
          for (int k = 0; k < PIN_N; k++) begin
            nxt_state.mc = nxt_state.mc | op_m[op_stream_in][k];
          end
          for (int k = 0; k < TC_N; k++) begin
            if (op_m[op_stream_in][PIN_N+k]) begin
              nxt_state.tc[op_stream_in][k].valid = 1'h0;
            end
          end
          nxt_state.pin[op_stream_in][op_slot_in] = new_ent;
        end
        TLB_OP_PRG_PIN: begin
          for (int k = 0; k < PIN_N; k++) begin
            if (op_m[op_stream_in][k]) begin
              nxt_state.pin[op_stream_in][k].valid = 1'h0;
            end
          end
          // Same-stream cache overlaps go too
          for (int k = 0; k < TC_N; k++) begin
            if (op_m[op_stream_in][PIN_N+k]) begin
              nxt_state.tc[op_stream_in][k].valid = 1'h0;
            end
          end
        end
        TLB_OP_INS_TC: begin
          // Purge overlaps, then take a free slot or the pointer slot
          for (int k = TC_N - 1; k >= 0; k--) begin
            if (op_m[op_stream_in][PIN_N+k]) begin
              nxt_state.tc[op_stream_in][k].valid = 1'h0;
            end
            if (!nxt_state.tc[op_stream_in][k].valid) begin
              victim = k[1:0];
              found = 1'h1;
            end
          end
          if (!found && state_ff.fp != TLB_FP_IDLE && state_ff.last_str == op_stream_in &&
              victim == state_ff.last_idx) begin
            victim = victim + 2'h1;
          end
          nxt_state.tc[op_stream_in][victim] = new_ent;
          nxt_state.ptr[op_stream_in] = victim + 2'h1;
          nxt_state.last_str = op_stream_in;
          nxt_state.last_idx = victim;
          nxt_state.fp = TLB_FP_HOLD;
        end
        TLB_OP_PRG_LOC, TLB_OP_PRG_GLB: begin
          for (int s = 0; s < STR_N; s++) begin
            for (int k = 0; k < TC_N; k++) begin
              if (op_m[s][PIN_N+k]) begin
                nxt_state.tc[s][k].valid = 1'h0;
              end
            end
          end
          if (op_code_in == TLB_OP_PRG_GLB) begin
            nxt_state.gp = 1'h1;
            nxt_state.gp_va = q_va;
            nxt_state.gp_ps = q_ps;
            nxt_state.gp_rid = q_rid;
          end
        end
        TLB_OP_PRG_ENT: begin
          // Overpurge: one command empties both local caches
          for (int s = 0; s < STR_N; s++) begin
            for (int k = 0; k < TC_N; k++) begin
              nxt_state.tc[s][k].valid = 1'h0;
            end
          end
        end
        default: begin
        end
      endcase
    end else if (remote_purge_valid_in) begin
      for (int s = 0; s < STR_N; s++) begin
        for (int k = 0; k < TC_N; k++) begin
          if (op_m[s][PIN_N+k]) begin
            nxt_state.tc[s][k].valid = 1'h0;
          end
        end
      end
    end
  end

  // State register
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs straight from the state
  assign instr_resp_valid_out = state_ff.i_rv;
  assign instr_hit_out = state_ff.i_hit;
  assign instr_miss_out = state_ff.i_miss;
  assign instr_pa_out = state_ff.i_pa;
  assign data_resp_valid_out = state_ff.d_rv;
  assign data_hit_out = state_ff.d_hit;
  assign data_miss_out = state_ff.d_miss;
  assign data_pa_out = state_ff.d_pa;
  assign data_resp_src_out = state_ff.d_src;
  assign machine_check_out = state_ff.mc;
  assign corrected_check_out = state_ff.cmc;
  assign global_purge_out = state_ff.gp;
  assign global_purge_va_out = state_ff.gp_va;
  assign global_purge_ps_out = state_ff.gp_ps;
  assign global_purge_rid_out = state_ff.gp_rid;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  // Unmatched fetch answers next cycle as a miss, not a hit
  property p_miss;
    instr_req_valid_in && !lk_hit[STR_INSTR] |=> instr_resp_valid_out && instr_miss_out && !instr_hit_out;
  endproperty
  a_miss: assert property (p_miss) else $error("fetch miss not reported");
  property p_hit_pa;
    data_req_valid_in && lk_hit[STR_DATA] |=> data_hit_out && data_pa_out == $past(lk_pa[STR_DATA]);
  endproperty
  a_hit_pa: assert property (p_hit_pa) else $error("data hit answer wrong");
  property p_src;
    data_req_valid_in |=> data_resp_valid_out && data_resp_src_out == $past(data_src_in);
  endproperty
  a_src: assert property (p_src) else $error("data requester not echoed");
  property p_pin_ins;
    op_valid_in && op_code_in == TLB_OP_INS_PIN && !hw_error_in
      |=> state_ff.pin[$past(op_stream_in)][$past(op_slot_in)].valid;
  endproperty
  a_pin_ins: assert property (p_pin_ins) else $error("pinned insert missed slot");
  property p_pin_kept;
    state_ff.pin[STR_DATA][0].valid && !hw_error_in &&
      !(op_valid_in && (op_code_in == TLB_OP_PRG_PIN || op_code_in == TLB_OP_INS_PIN))
      |=> state_ff.pin[STR_DATA][0].valid;
  endproperty
  a_pin_kept: assert property (p_pin_kept) else $error("pinned entry lost");
  property p_err_mc;
    hw_error_in && state_ff.pin[STR_INSTR][0].valid |=> machine_check_out ##1 !state_ff.pin[STR_INSTR][0].valid;
  endproperty
  a_err_mc: assert property (p_err_mc) else $error("error drop not reported");
  property p_global;
    op_valid_in && !hw_error_in && op_code_in == TLB_OP_PRG_GLB |=> global_purge_out ##1
      (!global_purge_out || $past(op_valid_in && !hw_error_in && op_code_in == TLB_OP_PRG_GLB));
  endproperty
  a_global: assert property (p_global) else $error("global purge not broadcast");
  property p_entry;
    op_valid_in && !hw_error_in && op_code_in == TLB_OP_PRG_ENT
      |=> !global_purge_out && !state_ff.tc[STR_DATA][0].valid && !state_ff.tc[STR_INSTR][3].valid;
  endproperty
  a_entry: assert property (p_entry) else $error("entry purge not local or incomplete");
  property p_hold;
    state_ff.fp != TLB_FP_IDLE && state_ff.tc[state_ff.last_str][state_ff.last_idx].valid &&
      !hw_error_in && !op_valid_in && !remote_purge_valid_in
      |=> state_ff.tc[$past(state_ff.last_str)][$past(state_ff.last_idx)].valid;
  endproperty
  a_hold: assert property (p_hold) else $error("held cache entry dropped");
  c_pin_hit: cover property (instr_req_valid_in && lk_m[STR_INSTR][0]);
  c_tc_hit: cover property (data_req_valid_in && lk_m[STR_DATA][PIN_N]);
  c_remote: cover property (remote_purge_valid_in && remote_purge_ready_out && op_m[STR_DATA][PIN_N]);
  c_armed: cover property (state_ff.fp == TLB_FP_ARMED ##1 state_ff.fp == TLB_FP_IDLE);
endmodule : tlb_buffer
`default_nettype wire

// [testbench/tlb_remote_cpu.sv]
/*
  Remote processor model: sends one incoming global purge per start pulse.
  Assumes the buffer samples valid and ready on the rising clock edge.
*/
`timescale 1ns/10ps
`default_nettype none
module tlb_remote_cpu (
  input wire logic clock_in, // Core clock
  input wire logic start_in, // Send one purge
  input wire logic [60:0] va_in, // Purge address
  input wire logic [5:0] ps_in, // Purge page size
  input wire logic [23:0] rid_in, // Purge region
  input wire logic ready_in, // Buffer takes purge
  output logic valid_out = 1'h0, // Purge request
  output logic [60:0] va_out = 61'h0, // Address on the wire
  output logic [5:0] ps_out = 6'h0, // Size on the wire
  output logic [23:0] rid_out = 24'h0, // Region on the wire
  output logic done_out = 1'h0 // Purge was taken
);
  // Hold request until taken, then scramble the released lines
  always @(posedge clock_in) begin
    done_out <= 1'h0;
    if (valid_out && ready_in) begin
      valid_out <= 1'h0;
      va_out <= ~va_out;
      ps_out <= ~ps_out;
      rid_out <= ~rid_out;
      done_out <= 1'h1;
    end else if (start_in && !valid_out) begin
      valid_out <= 1'h1;
      va_out <= va_in;
      ps_out <= ps_in;
      rid_out <= rid_in;
    end
  end
endmodule : tlb_remote_cpu
`default_nettype wire

// [testbench/translation_lookaside_buffer_test.sv]
/*
  Self-checking bench for the translation buffer: lookups, pinned and
  cache maintenance, purges and errors. Assumes the remote purge model.
*/
`timescale 1ns/10ps
`default_nettype none
module translation_lookaside_buffer_test;
  import tlb_pkg::*;
  localparam logic [63:0] VA1 = 64'h40_3000, VA2 = 64'h80_5000, VA3 = 64'hc0_7000;
  localparam logic [49:0] PA1 = 50'h123_4000, PA2 = 50'h55_6000, PA3 = 50'h77_8000;
  logic clock_in = 1'h0, reset_in = 1'h1, rr_write_in = 1'h0, op_valid_in = 1'h0, op_stream_in = 1'h0;
  logic instr_req_valid_in = 1'h0, data_req_valid_in = 1'h0, hw_error_in = 1'h0, rp_start = 1'h0, rp_done;
  logic interruption_collection_in = 1'h0, rfi_in = 1'h0, insn_done_in = 1'h0;
  logic remote_purge_valid_in, remote_purge_ready_out, global_purge_out, machine_check_out, corrected_check_out;
  logic instr_resp_valid_out, instr_hit_out, instr_miss_out, data_resp_valid_out, data_hit_out, data_miss_out;
  logic [2:0] rr_index_in = 3'h0, op_slot_in = 3'h0;
  logic [RID_W-1:0] rr_rid_in = 24'h0, remote_purge_rid_in, global_purge_rid_out;
  tlb_op_t op_code_in = TLB_OP_INS_PIN;
  logic [VA_W-1:0] op_va_in = 64'h0, instr_va_in = 64'h0, data_va_in = 64'h0;
  logic [PS_W-1:0] op_ps_in = 6'h0c, remote_purge_ps_in, global_purge_ps_out;
  logic [PA_W-1:0] op_pa_in = 50'h0, instr_pa_out, data_pa_out;
  logic [VPN_W-1:0] remote_purge_va_in, global_purge_va_out;
  tlb_src_t data_src_in = TLB_SRC_DATA, data_resp_src_out;
  int fails = 0, checks = 0;
  // Buffer under test, every port by its own name
  tlb_buffer uut (.*);
  // Far-side processor sending incoming purges
  tlb_remote_cpu rcpu (.clock_in(clock_in), .start_in(rp_start), .va_in(VA2[60:0]), .ps_in(6'h0c),
    .rid_in(24'h0), .ready_in(remote_purge_ready_out), .valid_out(remote_purge_valid_in),
    .va_out(remote_purge_va_in), .ps_out(remote_purge_ps_in), .rid_out(remote_purge_rid_in), .done_out(rp_done));
  // 50 MHz clock
  initial begin
    forever #10 clock_in = !clock_in;
  end
  // Compare and count
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One maintenance command, page size 4 KiB
  task automatic op(input tlb_op_t code, input logic strm, input logic [2:0] slot, input logic [63:0] va,
    input logic [49:0] pa);
    @(negedge clock_in);
    op_code_in = code;
    op_stream_in = strm;
    op_slot_in = slot;
    op_va_in = va;
    op_pa_in = pa;
    op_valid_in = 1'h1;
    @(negedge clock_in);
    op_valid_in = 1'h0;
  endtask : op
  // One lookup, answer judged the cycle after
  task automatic look(input logic strm, input logic [63:0] va, input logic hit, input logic [49:0] pa);
    logic [54:0] e;
    e = {1'h1, hit, !hit, data_src_in, hit ? pa : 50'h0};
    @(negedge clock_in);
    instr_va_in = va;
    data_va_in = va;
    instr_req_valid_in = !strm;
    data_req_valid_in = strm;
    @(negedge clock_in);
    if (strm) chk({data_resp_valid_out, data_hit_out, data_miss_out, data_resp_src_out, data_pa_out}, e);
    else chk({instr_resp_valid_out, instr_hit_out, instr_miss_out, data_src_in, instr_pa_out}, e);
    instr_req_valid_in = 1'h0;
    data_req_valid_in = 1'h0;
  endtask : look
  // Verdict and end of run
  task automatic test_done;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  // Watchdog
  initial begin
    repeat (3000) @(posedge clock_in);
    fails++;
    test_done;
  end
  // Main sequence
  initial begin
    repeat (10) @(negedge clock_in);
    reset_in = 1'h0;
    chk({instr_resp_valid_out, data_resp_valid_out, machine_check_out, global_purge_out}, 4'h0);
    look(1'h1, VA1, 1'h0, PA1);
    // Pinned insert, walker request, stream split
    data_src_in = TLB_SRC_WALK;
    op(TLB_OP_INS_PIN, 1'h1, 3'h0, VA1, PA1);
    look(1'h1, VA1, 1'h1, PA1);
    data_src_in = TLB_SRC_SPILL;
    look(1'h0, VA1, 1'h0, PA1);
    $display("pinned done");
    // Cache inserts both streams, one local purge
    op(TLB_OP_INS_TC, 1'h1, 3'h0, VA2, PA2);
    op(TLB_OP_INS_TC, 1'h0, 3'h0, VA2, PA3);
    look(1'h0, VA2, 1'h1, PA3);
    op(TLB_OP_PRG_LOC, 1'h1, 3'h0, VA2, PA2);
    look(1'h1, VA2, 1'h0, PA2);
    look(1'h0, VA2, 1'h0, PA3);
    look(1'h1, VA1, 1'h1, PA1);
    $display("local purge done");
    // Global purge broadcast
    op(TLB_OP_INS_TC, 1'h0, 3'h0, VA2, PA2);
    op(TLB_OP_PRG_GLB, 1'h1, 3'h0, VA2, PA2);
    chk({global_purge_out, global_purge_ps_out, global_purge_rid_out}, {1'h1, 6'h0c, 24'h0});
    chk(global_purge_va_out, VA2[60:0]);
    look(1'h0, VA2, 1'h0, PA2);
    // Incoming remote purge
    op(TLB_OP_INS_TC, 1'h1, 3'h0, VA2, PA2);
    @(negedge clock_in);
    rp_start = 1'h1;
    @(negedge clock_in);
    rp_start = 1'h0;
    for (int i = 0; i < 20 && !rp_done; i++) @(negedge clock_in);
    look(1'h1, VA2, 1'h0, PA2);
    $display("global purge done");
    // Overlap check, pinned purge keeps other stream
    op(TLB_OP_INS_PIN, 1'h1, 3'h0, VA1, PA1);
    chk(machine_check_out, 1'h1);
    op(TLB_OP_INS_PIN, 1'h0, 3'h0, VA1, PA3);
    op(TLB_OP_PRG_PIN, 1'h1, 3'h5, VA1, PA1);
    look(1'h1, VA1, 1'h0, PA1);
    look(1'h0, VA1, 1'h1, PA3);
    $display("pinned purge done");
    // Purge of all entries stays local
    op(TLB_OP_INS_TC, 1'h1, 3'h0, VA2, PA2);
    op(TLB_OP_INS_TC, 1'h0, 3'h0, VA3, PA3);
    op(TLB_OP_PRG_ENT, 1'h1, 3'h0, VA3, PA3);
    @(negedge clock_in);
    chk(global_purge_out, 1'h0);
    look(1'h1, VA2, 1'h0, PA2);
    look(1'h0, VA3, 1'h0, PA3);
    // Region identifier selected by top bits
    @(negedge clock_in);
    rr_index_in = 3'h2;
    rr_rid_in = 24'h5;
    rr_write_in = 1'h1;
    @(negedge clock_in);
    rr_write_in = 1'h0;
    op(TLB_OP_INS_PIN, 1'h1, 3'h1, 64'h4000_0000_0000_9000, PA1);
    look(1'h1, 64'h6000_0000_0000_9000, 1'h0, PA1);
    look(1'h1, 64'h4000_0000_0000_9000, 1'h1, PA1);
    // Cache overflow never evicts a pinned entry
    for (int i = 0; i < 6; i++) op(TLB_OP_INS_TC, 1'h1, 3'h0, 64'h100_0000 + (i << 12), PA2);
    look(1'h1, 64'h4000_0000_0000_9000, 1'h1, PA1);
    look(1'h1, 64'h100_5000, 1'h1, PA2);
    // Return, then one clean instruction with collection on
    @(negedge clock_in);
    rfi_in = 1'h1;
    @(negedge clock_in);
    rfi_in = 1'h0;
    interruption_collection_in = 1'h1;
    insn_done_in = 1'h1;
    @(negedge clock_in);
    insn_done_in = 1'h0;
    interruption_collection_in = 1'h0;
    $display("region and replacement done");
    // Hardware error drops everything and reports
    @(negedge clock_in);
    hw_error_in = 1'h1;
    @(negedge clock_in);
    hw_error_in = 1'h0;
    chk({machine_check_out, corrected_check_out}, 2'h3);
    look(1'h0, VA1, 1'h0, PA3);
    $display("error done");
    test_done;
  end
endmodule : translation_lookaside_buffer_test
`default_nettype wire
